//--- inc/dlf_pkg.sv
// Constants, state encodings and carrier types of the debug link flash front end
`default_nettype none
package dlf_pkg;
   // Register selector values seen through the link address register
   localparam logic [7:0] DLF_ADDR_CTL       = 8'h02;
   localparam logic [7:0] DLF_ADDR_DAT       = 8'hb4;
   // Reset values
   localparam logic [7:0] DLF_CTL_RESET      = 8'h00;
   localparam logic [7:0] DLF_DAT_RESET      = 8'h00;
   localparam logic [7:0] DLF_SEL_RESET      = 8'h00;
   localparam logic [7:0] DLF_READ_ZERO      = 8'h00;
   // Unlock codes, in the order they must arrive
   localparam logic [7:0] DLF_UNLOCK_FIRST   = 8'h02;
   localparam logic [7:0] DLF_UNLOCK_SECOND  = 8'h01;
   // Flash command codes
   localparam logic [7:0] DLF_CMD_BLOCK_RD   = 8'h06;
   localparam logic [7:0] DLF_CMD_BLOCK_WR   = 8'h07;
   localparam logic [7:0] DLF_CMD_PAGE_ERASE = 8'h08;
   localparam logic [7:0] DLF_CMD_DEV_ERASE  = 8'h03;
   // Frame layout: start bit, two instruction bits, eight data bits, answer bits
   localparam logic [3:0] DLF_INS_LAST       = 4'h1;
   localparam logic [3:0] DLF_BYTE_LAST      = 4'h7;
   localparam logic [3:0] DLF_BYTE_BITS      = 4'h8;
   localparam logic [3:0] DLF_ACK_BITS       = 4'h1;
   localparam logic [3:0] DLF_CNT_ZERO       = 4'h0;
   localparam logic [7:0] DLF_ACK_OK         = 8'h01;
   localparam logic [7:0] DLF_ACK_FULL       = 8'h00;
   // Instruction codes
   localparam logic [1:0] DLF_INS_DATA_RD    = 2'h0;
   localparam logic [1:0] DLF_INS_DATA_WR    = 2'h1;
   localparam logic [1:0] DLF_INS_ADDR_RD    = 2'h2;
   localparam logic [1:0] DLF_INS_ADDR_WR    = 2'h3;

   typedef enum logic [2:0] {
      UL_LOCKED  = 3'b001,
      UL_FIRST   = 3'b010,
      UL_ENABLED = 3'b100
   } dlf_unlock_e;

   typedef enum logic [3:0] {
      LK_IDLE  = 4'b0001,
      LK_INS   = 4'b0010,
      LK_WDAT  = 4'b0100,
      LK_DRIVE = 4'b1000
   } dlf_link_e;

   typedef struct packed {
      logic       known_cmd;
      logic [7:0] data;
   } dlf_word_s;
endpackage : dlf_pkg
`default_nettype wire

//--- verilog/dlf_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`default_nettype none
module dlf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem_r[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count_r <= '0;
      end else if (push && !pop) begin
         count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
         count_r <= count_r - 1'b1;
      end
   end
endmodule : dlf_fifo
`default_nettype wire

//--- verilog/dlf_link_flash.sv
// Debug link front end: link framing, programming unlock, data register and flash byte queue
// Summary of operation
// - Control register at link address 0x02, resets zero
// - Programming unlocks after 0x02 then 0x01
// - Programming stays enabled until system reset
// - Data register at link address 0xB4, resets zero
// - Data register carries commands; 0x06 read, 0x07 write
// - Command 0x08 page erase, 0x03 device erase
// - Halted device stalls peripherals and user code
// - Halted link owns shared clock and data pins
// - Address register selects target of data accesses
// - Host clock plus one shared bidirectional data line
`default_nettype none
module dlf_link_flash
   import dlf_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       halt_req,
   input  wire logic       debug_link_clock,
   input  wire logic       debug_link_data_in,
   output logic            debug_link_data_out,
   output logic            debug_link_data_oe,
   output logic            core_stall,
   output logic            pins_borrowed,
   output logic            prog_enabled,
   output logic            flash_valid,
   input  wire logic       flash_ready,
   output dlf_word_s       flash_word,
   input  wire logic       flash_rd_valid,
   input  wire logic [7:0] flash_rd_data
);
   ////////////////////////////////////////////////////////////////////////////////
   logic        ck_s1_r, ck_s2_r, ck_d_r;
   logic        dt_s1_r, dt_s2_r;
   logic        ck_rise, ck_fall;
   dlf_link_e   link_r;
   dlf_unlock_e unlock_r;
   logic [3:0]  cnt_r;
   logic [1:0]  ins_r;
   logic [1:0]  ins_now;
   logic [7:0]  shift_r;
   logic [7:0]  tx_r;
   logic [7:0]  wr_byte;
   logic [7:0]  ctl_r;
   logic [7:0]  dat_r;
   logic [7:0]  sel_r;
   logic [7:0]  rd_value;
   logic        ins_done, wr_done;
   logic        ctl_wr, dat_wr, sel_wr;
   logic        push_valid, push_ready;
   logic        stall_r, borrow_r, prog_r, out_r, oe_r;
   dlf_word_s   push_word;

   // Pins come from the host's domain; the second stage and its delayed copy ck_d_r feed logic
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_d_r  <= 1'b0;
         dt_s1_r <= 1'b1;
         dt_s2_r <= 1'b1;
      end else begin
         ck_s1_r <= debug_link_clock;
         ck_s2_r <= ck_s1_r;
         ck_d_r  <= ck_s2_r;
         dt_s1_r <= debug_link_data_in;
         dt_s2_r <= dt_s1_r;
      end
   end

   // Framing only runs while the link holds the pins
   assign ck_rise = ck_s2_r & ~ck_d_r & borrow_r;
   assign ck_fall = ~ck_s2_r & ck_d_r & borrow_r;

   ////////////////////////////////////////////////////////////////////////////////
   assign ins_now  = {dt_s2_r, ins_r[1]};
   assign wr_byte  = {dt_s2_r, shift_r[7:1]};
   assign ins_done = ck_rise && (link_r == LK_INS) && (cnt_r == DLF_INS_LAST);
   assign wr_done  = ck_rise && (link_r == LK_WDAT) && (cnt_r == DLF_BYTE_LAST);
   assign sel_wr   = wr_done && (ins_r == DLF_INS_ADDR_WR);
   assign ctl_wr   = wr_done && (ins_r == DLF_INS_DATA_WR) && (sel_r == DLF_ADDR_CTL);
   assign dat_wr   = wr_done && (ins_r == DLF_INS_DATA_WR) && (sel_r == DLF_ADDR_DAT);

   always_comb begin
      if (ins_now == DLF_INS_ADDR_RD) begin
         rd_value = sel_r;
      end else if (sel_r == DLF_ADDR_CTL) begin
         rd_value = ctl_r;
      end else if (sel_r == DLF_ADDR_DAT) begin
         rd_value = dat_r;
      end else begin
         rd_value = DLF_READ_ZERO;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         link_r  <= LK_IDLE;
         cnt_r   <= DLF_CNT_ZERO;
         ins_r   <= DLF_INS_DATA_RD;
         shift_r <= DLF_READ_ZERO;
         tx_r    <= DLF_READ_ZERO;
         out_r   <= 1'b1;
         oe_r    <= 1'b0;
      end else begin
         case (link_r)
            LK_IDLE: begin
               oe_r <= 1'b0;
               if (ck_rise && !dt_s2_r) begin
                  link_r <= LK_INS;
                  cnt_r  <= DLF_CNT_ZERO;
               end
            end
            LK_INS: begin
               if (ck_rise) begin
                  ins_r <= ins_now;
                  cnt_r <= cnt_r + 4'h1;
                  if (ins_done && ins_now[0]) begin
                     link_r <= LK_WDAT;
                     cnt_r  <= DLF_CNT_ZERO;
                  end else if (ins_done) begin
                     link_r <= LK_DRIVE;
                     tx_r   <= rd_value;
                     cnt_r  <= DLF_BYTE_BITS;
                  end
               end
            end
            LK_WDAT: begin
               if (ck_rise) begin
                  shift_r <= wr_byte;
                  cnt_r   <= cnt_r + 4'h1;
                  if (wr_done) begin
                     link_r <= LK_DRIVE;
                     cnt_r  <= DLF_ACK_BITS;
                     // A data write that finds the queue full is answered with a zero
                     tx_r   <= (dat_wr && prog_r && !push_ready) ? DLF_ACK_FULL : DLF_ACK_OK;
                  end
               end
            end
            LK_DRIVE: begin
               if (ck_fall) begin
                  if (cnt_r != DLF_CNT_ZERO) begin
                     out_r <= tx_r[0];
                     oe_r  <= 1'b1;
                     tx_r  <= {1'b0, tx_r[7:1]};
                     cnt_r <= cnt_r - 4'h1;
                  end else begin
                     oe_r   <= 1'b0;
                     out_r  <= 1'b1;
                     link_r <= LK_IDLE;
                  end
               end
            end
            default: begin
               link_r <= LK_IDLE;
               oe_r   <= 1'b0;
            end
         endcase
         // Abandon the frame on the edge that hands the pins back, so oe never outlives ownership
         if (!(halt_req | prog_r)) begin
            link_r <= LK_IDLE;
            oe_r   <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sel_r <= DLF_SEL_RESET;
      end else if (sel_wr) begin
         sel_r <= wr_byte;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctl_r <= DLF_CTL_RESET;
      end else if (ctl_wr) begin
         ctl_r <= wr_byte;
      end
   end

   // Returned flash bytes win over a host write landing in the same cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dat_r <= DLF_DAT_RESET;
      end else if (flash_rd_valid) begin
         dat_r <= flash_rd_data;
      end else if (dat_wr) begin
         dat_r <= wr_byte;
      end
   end

   // Only system reset leaves the enabled state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         unlock_r <= UL_LOCKED;
      end else if (ctl_wr) begin
         case (unlock_r)
            UL_LOCKED: begin
               unlock_r <= (wr_byte == DLF_UNLOCK_FIRST) ? UL_FIRST : UL_LOCKED;
            end
            UL_FIRST: begin
               unlock_r <= (wr_byte == DLF_UNLOCK_SECOND) ? UL_ENABLED : UL_LOCKED;
            end
            UL_ENABLED: begin
               unlock_r <= UL_ENABLED;
            end
            default: begin
               unlock_r <= UL_LOCKED;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prog_r   <= 1'b0;
         stall_r  <= 1'b0;
         borrow_r <= 1'b0;
      end else begin
         prog_r   <= prog_r | (ctl_wr && (unlock_r == UL_FIRST) &&
                               (wr_byte == DLF_UNLOCK_SECOND));
         stall_r  <= halt_req | prog_r;
         borrow_r <= halt_req | prog_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign push_valid          = dat_wr & prog_r;
   assign push_word.data      = wr_byte;
   assign push_word.known_cmd = (wr_byte == DLF_CMD_BLOCK_RD) || (wr_byte == DLF_CMD_BLOCK_WR) ||
                                (wr_byte == DLF_CMD_PAGE_ERASE) ||
                                (wr_byte == DLF_CMD_DEV_ERASE);

   dlf_fifo #(
      .WIDTH ($bits(dlf_word_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_word),
      .out_valid (flash_valid),
      .out_ready (flash_ready),
      .out_data  (flash_word)
   );

   assign debug_link_data_out = out_r;
   assign debug_link_data_oe  = oe_r;
   assign core_stall          = stall_r;
   assign pins_borrowed       = borrow_r;
   assign prog_enabled        = prog_r;

   ////////////////////////////////////////////////////////////////////////////////
   sequence s_first_code;
      ctl_wr && unlock_r == UL_LOCKED && wr_byte == DLF_UNLOCK_FIRST;
   endsequence
   sequence s_second_code;
      ctl_wr && unlock_r == UL_FIRST && wr_byte == DLF_UNLOCK_SECOND;
   endsequence

   property p_first;
      @(posedge ref_clk) disable iff (reset)
      s_first_code |=> unlock_r == UL_FIRST && !prog_enabled;
   endproperty
   a_first: assert property (p_first) else $error("first unlock code not taken");

   property p_unlock;
      @(posedge ref_clk) disable iff (reset)
      s_second_code |=> prog_enabled;
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock pair did not enable");

   property p_sticky;
      @(posedge ref_clk) disable iff (reset)
      prog_enabled |=> prog_enabled && core_stall;
   endproperty
   a_sticky: assert property (p_sticky) else $error("programming left without reset");

   property p_relock;
      @(posedge ref_clk) disable iff (reset)
      (ctl_wr && unlock_r == UL_FIRST && wr_byte != DLF_UNLOCK_SECOND) |=> ##1 !prog_enabled;
   endproperty
   a_relock: assert property (p_relock) else $error("bad order enabled programming");

   property p_ctl_store;
      @(posedge ref_clk) disable iff (reset)
      ctl_wr |=> ctl_r == $past(wr_byte);
   endproperty
   a_ctl_store: assert property (p_ctl_store) else $error("control write lost");

   property p_dat_store;
      @(posedge ref_clk) disable iff (reset)
      (dat_wr && !flash_rd_valid) |=> dat_r == $past(wr_byte);
   endproperty
   a_dat_store: assert property (p_dat_store) else $error("data write lost");

   property p_cmd_flag;
      @(posedge ref_clk) disable iff (reset)
      push_valid && (wr_byte == DLF_CMD_DEV_ERASE || wr_byte == DLF_CMD_BLOCK_WR) |->
         push_word.known_cmd;
   endproperty
   a_cmd_flag: assert property (p_cmd_flag) else $error("command code not flagged");

   property p_stall;
      @(posedge ref_clk) disable iff (reset)
      halt_req |=> core_stall ##0 pins_borrowed;
   endproperty
   a_stall: assert property (p_stall) else $error("halt did not stall core");

   property p_pins;
      @(posedge ref_clk) disable iff (reset)
      debug_link_data_oe |-> pins_borrowed;
   endproperty
   a_pins: assert property (p_pins) else $error("data driven without pin ownership");

   property p_select;
      @(posedge ref_clk) disable iff (reset)
      sel_wr |=> (sel_r == $past(wr_byte)) ##1 $stable(sel_r);
   endproperty
   a_select: assert property (p_select) else $error("selector not updated");

   property p_start;
      @(posedge ref_clk) disable iff (reset)
      (link_r == LK_IDLE && ck_rise && !dt_s2_r && (halt_req || prog_r)) |=> link_r == LK_INS;
   endproperty
   a_start: assert property (p_start) else $error("start bit not taken");
endmodule : dlf_link_flash
`default_nettype wire

//--- verification/dlf_host_model.sv
// Behavioural programming host that frames transfers on the debug link
`default_nettype none
module dlf_host_model (
   output logic      debug_link_clock,
   output logic      host_data,
   output logic      host_oe,
   input  wire logic debug_link_data
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      debug_link_clock = 1'b0;
      host_data        = 1'b1;
      host_oe          = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One frame: start bit, instruction, write byte on writes only, then the device's answer
   // Writes return the ack bit in rdat[7], reads the byte LSB first
   task automatic frame(input logic [1:0] ins, input logic [7:0] wdat, output logic [7:0] rdat);
      logic [11:0] bits;
      int          n;
      bits = {1'b1, wdat, ins, 1'b0};
      n    = ins[0] ? 12 : 11;
      rdat = 8'h00;
      // Clock stands still between frames; the gap also lets the device drop its enable
      #203;
      for (int i = 0; i < n; i++) begin
         host_oe   = (i < 3) || (ins[0] && i < 11);
         host_data = host_oe ? bits[i] : 1'b1;
         #100;
         rdat = {debug_link_data, rdat[7:1]};
         debug_link_clock = 1'b1;
         #100;
         debug_link_clock = 1'b0;
      end
      host_oe   = 1'b0;
      host_data = 1'b1;
   endtask : frame
endmodule : dlf_host_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench: unlock sequence, register map and flash byte queue over the link
`default_nettype none
module tb;
   import dlf_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic       ref_clk = 1'b0;
   logic       reset;
   logic       halt_req;
   logic       link_clk;
   logic       host_data;
   logic       host_oe;
   logic       dut_data;
   logic       dut_oe;
   logic       core_stall;
   logic       pins_borrowed;
   logic       prog_enabled;
   logic       flash_valid;
   logic       flash_ready;
   dlf_word_s  flash_word;
   logic       flash_rd_valid;
   logic [7:0] flash_rd_data;
   wire        debug_link_data;
   int         n_fail     = 0;
   int         n_compared = 0;
   logic [7:0] r;
   logic [7:0] codes [5] = '{8'h06, 8'h07, 8'h08, 8'h03, 8'h5a};

   always #12.5 ref_clk = ~ref_clk;

   // Pulled-up line: reads 1 when nobody drives it
   assign debug_link_data = dut_oe ? dut_data : (host_oe ? host_data : 1'b1);

   dlf_link_flash #(.FIFO_DEPTH(2)) i_dut (
      .ref_clk             (ref_clk),
      .reset               (reset),
      .halt_req            (halt_req),
      .debug_link_clock    (link_clk),
      .debug_link_data_in  (debug_link_data),
      .debug_link_data_out (dut_data),
      .debug_link_data_oe  (dut_oe),
      .core_stall          (core_stall),
      .pins_borrowed       (pins_borrowed),
      .prog_enabled        (prog_enabled),
      .flash_valid         (flash_valid),
      .flash_ready         (flash_ready),
      .flash_word          (flash_word),
      .flash_rd_valid      (flash_rd_valid),
      .flash_rd_data       (flash_rd_data)
   );

   dlf_host_model i_host (
      .debug_link_clock (link_clk),
      .host_data        (host_data),
      .host_oe          (host_oe),
      .debug_link_data  (debug_link_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (n_fail == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask : check

   task automatic xfer(input logic [1:0] ins, input logic [7:0] d, output logic [7:0] q);
      i_host.frame(ins, d, q);
      @(negedge ref_clk);
   endtask : xfer

   task automatic reg_wr(input logic [7:0] sel, input logic [7:0] d, output logic ack);
      logic [7:0] q;
      xfer(DLF_INS_ADDR_WR, sel, q);
      xfer(DLF_INS_DATA_WR, d, q);
      ack = q[7];
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] sel, output logic [7:0] q);
      xfer(DLF_INS_ADDR_WR, sel, q);
      xfer(DLF_INS_DATA_RD, 8'h00, q);
   endtask : reg_rd

   // Checks the queue head, then pops it with a one-cycle ready
   task automatic pop(input logic [8:0] exp);
      check(9'(flash_valid), 9'h001);
      check(flash_word, exp);
      flash_ready = 1'b1;
      @(negedge ref_clk);
      flash_ready = 1'b0;
   endtask : pop

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1ms;
      n_fail++;
      end_sim();
   end

   initial begin
      logic a;
      reset          = 1'b1;
      halt_req       = 1'b0;
      flash_ready    = 1'b0;
      flash_rd_valid = 1'b0;
      flash_rd_data  = 8'h00;
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      // Frames before the halt must be ignored
      xfer(DLF_INS_ADDR_WR, 8'hb4, r);
      check(9'(core_stall), 9'h000);
      check(9'(pins_borrowed), 9'h000);
      halt_req = 1'b1;
      repeat (2) @(negedge ref_clk);
      check(9'(core_stall), 9'h001);
      check(9'(pins_borrowed), 9'h001);
      xfer(DLF_INS_ADDR_RD, 8'h00, r);
      check(9'(r), 9'(DLF_SEL_RESET));
      reg_rd(DLF_ADDR_CTL, r);
      check(9'(r), 9'(DLF_CTL_RESET));
      reg_rd(DLF_ADDR_DAT, r);
      check(9'(r), 9'(DLF_DAT_RESET));
      reg_rd(8'h33, r);
      check(9'(r), 9'(DLF_READ_ZERO));
      xfer(DLF_INS_ADDR_RD, 8'h00, r);
      check(9'(r), 9'h033);
      // Locked: data writes are stored but not queued
      reg_wr(DLF_ADDR_DAT, 8'h5a, a);
      check(9'(flash_valid), 9'h000);
      reg_rd(DLF_ADDR_DAT, r);
      check(9'(r), 9'h05a);
      reg_wr(DLF_ADDR_CTL, DLF_UNLOCK_FIRST, a);
      reg_wr(DLF_ADDR_CTL, 8'h05, a);
      reg_wr(DLF_ADDR_CTL, DLF_UNLOCK_SECOND, a);
      check(9'(prog_enabled), 9'h000);
      reg_wr(DLF_ADDR_CTL, DLF_UNLOCK_FIRST, a);
      check(9'(prog_enabled), 9'h000);
      reg_wr(DLF_ADDR_CTL, DLF_UNLOCK_SECOND, a);
      check(9'(prog_enabled), 9'h001);
      reg_rd(DLF_ADDR_CTL, r);
      check(9'(r), 9'(DLF_UNLOCK_SECOND));
      halt_req = 1'b0;
      repeat (4) @(negedge ref_clk);
      check(9'(core_stall), 9'h001);
      check(9'(prog_enabled), 9'h001);
      // Every command code, then a plain data byte
      for (int i = 0; i < 5; i++) begin
         reg_wr(DLF_ADDR_DAT, codes[i], a);
         check(9'(a), 9'h001);
         pop({i < 4, codes[i]});
      end
      // Fill the two-deep queue until it refuses, then drain it
      reg_wr(DLF_ADDR_DAT, DLF_CMD_BLOCK_WR, a);
      reg_wr(DLF_ADDR_DAT, DLF_CMD_PAGE_ERASE, a);
      reg_wr(DLF_ADDR_DAT, DLF_CMD_DEV_ERASE, a);
      check(9'(a), 9'(DLF_ACK_FULL));
      pop({1'b1, DLF_CMD_BLOCK_WR});
      pop({1'b1, DLF_CMD_PAGE_ERASE});
      check(9'(flash_valid), 9'h000);
      flash_rd_data  = 8'hc3;
      flash_rd_valid = 1'b1;
      @(negedge ref_clk);
      flash_rd_valid = 1'b0;
      reg_rd(DLF_ADDR_DAT, r);
      check(9'(r), 9'h0c3);
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      @(negedge ref_clk);
      check(9'(prog_enabled), 9'h000);
      check(9'(core_stall), 9'h000);
      end_sim();
   end
endmodule : tb
`default_nettype wire
